/* File: common/rsc_pkg.sv */
// Purpose: shared constants for the reset strap configuration loader
// Assumes: 25 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes: byte offsets of one aligned word per register
`default_nettype none
package rsc_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RST_MIN_US = 200;
  localparam int unsigned RST_MIN_CYC = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_PULSE_MIN_US = 5;
  localparam int unsigned IRQ_PULSE_MAX_US = 36;
  localparam int unsigned IRQ_PULSE_US = 20;
  localparam int unsigned IRQ_PULSE_CYC = (IRQ_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_MIN_CYC = (IRQ_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_MAX_CYC = (IRQ_PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
  // ==========================================================
  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STRAP_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;
  localparam logic [7:0] CMD_OFS = 8'h10;
  // ==========================================================
  // field positions
  localparam int CTRL_PULSE_BIT = 0;
  localparam int STRAP_ROLE_BIT = 2;
  localparam int STRAP_GPIO_BIT = 3;
  localparam int STRAP_RST_BIT = 4;
  localparam int EV_SLIP_BIT = 0;
  localparam int EV_REJ_BIT = 1;
  localparam int EV_SHORT_BIT = 2;
  localparam int EV_W = 3;
  // ==========================================================
  // reset values and responses
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rsc_pkg
`default_nettype wire

/* File: design/rsc_loader.sv */
// Purpose: strap capture, chip address filter, role pins and event interrupt
// Assumes: straps held pulled while reset pin low; command word from serial decoder
// Notes: one clock domain; pins pass two flip-flops before use
//
// Summary of operation
// RQ1: device held in reset while reset pin low, runs once it returns high.
// RQ2: controller keeps reset pin low at least 200 us per reset.
// RQ3: with pulse option set, interrupt pin pulses low between 5 and 36 us.
// RQ4: strap pins are inputs while reset pin is low.
// RQ5: each strap must be pulled to a defined level while read.
// RQ6: chip address low bit from low strap, high bit from high strap.
// RQ7: four distinct chip addresses supported on one control bus.
// RQ8: chip address sits in the two least significant command bits.
// RQ9: command accepted only when its chip address equals strapped address.
// RQ10: role strap low selects master, high selects slave.
// RQ11: master drives bit and LR clocks; slave takes them as inputs.
// RQ12: slaves get clocks of equal polarity and matching reference from master.
// RQ13: slave sample slip is shown on interrupt and registers.
// RQ14: modulation and general purpose I/O never active together.
// RQ15: interrupt strap low enables modulation, high enables general I/O.
// RQ16: exactly one device should be strapped as master.
// RQ17: straps latched at reset release and held until next reset.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`default_nettype none
module rsc_loader
  import rsc_pkg::*;
#(
  parameter int unsigned CMD_W = 16,
  parameter int unsigned RST_MIN = RST_MIN_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // pins
  input wire logic reset_n_pin,
  input wire logic addr_strap_low_pin_in,
  output logic addr_strap_low_pin_out,
  output logic addr_strap_low_pin_oe,
  input wire logic addr_strap_high_pin_in,
  output logic addr_strap_high_pin_out,
  output logic addr_strap_high_pin_oe,
  input wire logic role_strap_pin_in,
  output logic role_strap_pin_out,
  output logic role_strap_pin_oe,
  input wire logic irq_n_pin_in,
  output logic irq_n_pin_out,
  output logic irq_n_pin_oe,
  input wire logic rx_bit_clock_in,
  output logic rx_bit_clock_out,
  output logic rx_bit_clock_oe,
  input wire logic rx_lr_clock_in,
  output logic rx_lr_clock_out,
  output logic rx_lr_clock_oe,
  output logic rx_master_clock_oe,
  // core side
  input wire logic low_func_out,
  input wire logic high_func_out,
  input wire logic role_func_out,
  input wire logic gen_bit_clock,
  input wire logic gen_lr_clock,
  output logic bit_clock_sync,
  output logic lr_clock_sync,
  input wire logic slip_event,
  input wire logic [CMD_W-1:0] cmd_word,
  input wire logic cmd_valid,
  output logic cmd_write,
  output logic [CMD_W-1:0] cmd_data,
  output logic sys_reset,
  output logic [1:0] chip_addr,
  output logic slave_role,
  output logic mod_enable,
  output logic gpio_enable
);

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [1:0] rstn_ff, lo_ff, hi_ff, role_ff, int_ff, bck_ff, lrck_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rstn_ff <= 2'h0;
      lo_ff <= 2'h0;
      hi_ff <= 2'h0;
      role_ff <= 2'h0;
      int_ff <= 2'h0;
      bck_ff <= 2'h0;
      lrck_ff <= 2'h0;
    end else begin
      rstn_ff <= {rstn_ff[0], reset_n_pin};
      lo_ff <= {lo_ff[0], addr_strap_low_pin_in};
      hi_ff <= {hi_ff[0], addr_strap_high_pin_in};
      role_ff <= {role_ff[0], role_strap_pin_in};
      int_ff <= {int_ff[0], irq_n_pin_in};
      bck_ff <= {bck_ff[0], rx_bit_clock_in};
      lrck_ff <= {lrck_ff[0], rx_lr_clock_in};
    end
  end
  assign bit_clock_sync = bck_ff[1];
  assign lr_clock_sync = lrck_ff[1];

  // ==========================================================
  // system reset and low width check
  logic in_reset;
  logic [31:0] low_cnt;
  logic short_ev;
  assign in_reset = ~rstn_ff[1]; // RQ1
  assign sys_reset = in_reset; // RQ1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 32'(RST_MIN); // rst counts as a full-length reset, never flagged short
      short_ev <= 1'b0;
    end else begin
      short_ev <= 1'b0;
      if (in_reset) begin
        if (low_cnt < RST_MIN) begin
          low_cnt <= low_cnt + 32'h1;
        end
      end else begin
        low_cnt <= 32'h0;
        if (low_cnt != 32'h0 && low_cnt < RST_MIN) begin
          short_ev <= 1'b1; // RQ2
        end
      end
    end
  end

  // ==========================================================
  // strap capture, frozen on release
  logic mod_strap;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chip_addr <= 2'h0;
      slave_role <= 1'b0;
      mod_strap <= 1'b0;
    end else if (in_reset) begin // RQ17
      chip_addr <= {hi_ff[1], lo_ff[1]}; // RQ6 RQ7
      slave_role <= role_ff[1]; // RQ10
      mod_strap <= int_ff[1];
    end
  end
  assign mod_enable = ~in_reset & ~mod_strap; // RQ15 RQ14
  assign gpio_enable = ~in_reset & mod_strap; // RQ15 RQ14

  // strap pins float as inputs during reset, then resume their functions
  assign addr_strap_low_pin_oe = ~in_reset; // RQ4
  assign addr_strap_high_pin_oe = ~in_reset; // RQ4
  assign role_strap_pin_oe = ~in_reset; // RQ4
  assign addr_strap_low_pin_out = low_func_out;
  assign addr_strap_high_pin_out = high_func_out;
  assign role_strap_pin_out = role_func_out;

  // ==========================================================
  // receive clock pin directions
  assign rx_master_clock_oe = ~in_reset; // RQ11
  assign rx_bit_clock_oe = ~in_reset & ~slave_role; // RQ11
  assign rx_lr_clock_oe = ~in_reset & ~slave_role; // RQ11
  assign rx_bit_clock_out = gen_bit_clock;
  assign rx_lr_clock_out = gen_lr_clock;

  // ==========================================================
  // command address filter
  logic rej_ev;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_write <= 1'b0;
      cmd_data <= '0;
      rej_ev <= 1'b0;
    end else begin
      cmd_write <= 1'b0;
      rej_ev <= 1'b0;
      if (cmd_valid && !in_reset) begin
        if (cmd_word[1:0] == chip_addr) begin // RQ8 RQ9
          cmd_write <= 1'b1;
          cmd_data <= cmd_word;
        end else begin
          rej_ev <= 1'b1; // RQ9
        end
      end
    end
  end

  // ==========================================================
  // registers and events
  logic [31:0] ctrl;
  logic [EV_W-1:0] stat, mask, ev, w1c;
  logic wr_go;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held, w_held;
  assign ev = {short_ev, rej_ev, slip_event & slave_role};
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign w1c = (wr_go && aw_addr == STAT_OFS && w_strb[0]) ? w_data[EV_W-1:0] : '0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~w1c) | ev; // RQ13
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      mask <= MASK_RST;
    end else if (wr_go) begin
      if (aw_addr == CTRL_OFS) begin
        ctrl <= apply_strb(ctrl, w_data, w_strb);
      end
      if (aw_addr == MASK_OFS && w_strb[0]) begin
        mask <= w_data[EV_W-1:0];
      end
    end
  end

  // ==========================================================
  // interrupt output and pin
  logic irq_act, irq_act_d, pulse_mode;
  logic [15:0] pulse_cnt;
  assign irq_act = |(stat & mask);
  assign irq = irq_act;
  assign pulse_mode = ctrl[CTRL_PULSE_BIT];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_act_d <= 1'b0;
      pulse_cnt <= 16'h0;
    end else begin
      irq_act_d <= irq_act;
      if (irq_act && !irq_act_d) begin
        pulse_cnt <= 16'(IRQ_PULSE_CYC); // RQ3
      end else if (pulse_cnt != 16'h0) begin
        pulse_cnt <= pulse_cnt - 16'h1;
      end
    end
  end
  assign irq_n_pin_oe = ~in_reset; // RQ4
  assign irq_n_pin_out = pulse_mode ? (pulse_cnt == 16'h0) : ~irq_act; // RQ3 RQ13

  // ==========================================================
  // AXI4-Lite write channel
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == CTRL_OFS || aw_addr == STAT_OFS || aw_addr == MASK_OFS ||
                        aw_addr == STRAP_OFS || aw_addr == CMD_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] next_rdata;
  logic [7:0] ra;
  assign s_axi_arready = ~s_axi_rvalid;
  always_comb begin
    ra = {s_axi_araddr[7:2], 2'h0};
    next_rdata = 32'h0;
    case (ra)
      CTRL_OFS: next_rdata = ctrl;
      STRAP_OFS: next_rdata = {27'h0, in_reset, mod_strap, slave_role, chip_addr};
      STAT_OFS: next_rdata = {29'h0, stat};
      MASK_OFS: next_rdata = {29'h0, mask};
      CMD_OFS: next_rdata = 32'(cmd_data);
      default: next_rdata = 32'h0;
    endcase
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (ra <= CMD_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  a_reset_holds: assert property (@(posedge core_clk) disable iff (rst) // RQ1
    in_reset |-> !mod_enable && !gpio_enable && !rx_bit_clock_oe && !rx_master_clock_oe)
    else $error("outputs active during reset");
  a_straps_input: assert property (@(posedge core_clk) disable iff (rst) // RQ4
    in_reset |-> !addr_strap_low_pin_oe && !role_strap_pin_oe && !irq_n_pin_oe)
    else $error("strap pin driven during reset");
  a_addr_form: assert property (@(posedge core_clk) disable iff (rst) // RQ6
    in_reset |=> chip_addr == $past(hi_ff[1]) * 2 + $past(lo_ff[1]))
    else $error("chip address not formed from straps");
  a_straps_frozen: assert property (@(posedge core_clk) disable iff (rst) // RQ17
    !in_reset && $past(!in_reset) |-> $stable(chip_addr) && $stable(slave_role)
      && $stable(mod_strap))
    else $error("strap value changed outside reset");
  a_addr_match: assert property (@(posedge core_clk) disable iff (rst) // RQ9
    cmd_valid && !in_reset && cmd_word[1:0] == chip_addr |=> cmd_write && !rej_ev)
    else $error("matching command not accepted");
  a_addr_ignore: assert property (@(posedge core_clk) disable iff (rst) // RQ9
    cmd_write |-> $past(cmd_valid) && $past(cmd_word[1:0]) == chip_addr)
    else $error("command accepted with wrong address");
  a_role_pins: assert property (@(posedge core_clk) disable iff (rst) // RQ11
    !in_reset |-> rx_bit_clock_oe == !slave_role && rx_lr_clock_oe == !slave_role
      && rx_master_clock_oe)
    else $error("clock pin direction wrong for role");
  a_func_excl: assert property (@(posedge core_clk) disable iff (rst) // RQ14
    !(mod_enable && gpio_enable))
    else $error("modulation and general I/O both active");
  a_func_select: assert property (@(posedge core_clk) disable iff (rst) // RQ15
    !in_reset |-> mod_enable == !mod_strap)
    else $error("shared pin function not from strap");
  a_pulse_width: assert property (@(posedge core_clk) disable iff (rst) // RQ3
    pulse_mode && $fell(irq_n_pin_out) && !in_reset |-> !irq_n_pin_out [*5]
      ##[1:900] irq_n_pin_out)
    else $error("interrupt pulse width out of range");
  a_slip_flag: assert property (@(posedge core_clk) disable iff (rst) // RQ13
    slip_event && slave_role |=> stat[EV_SLIP_BIT])
    else $error("slip event not flagged");

endmodule // rsc_loader
`default_nettype wire

/* File: dv/rsc_host_model.sv */
// Purpose: far-side model: strap pull resistors and serial command source
// Assumes: command words arrive from the serial decoder one per clock
// Notes: a released command word shows the inverse of its last value
`default_nettype none
module rsc_host_model (
  input wire logic core_clk,
  input wire logic [3:0] pull,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_in,
  output logic [15:0] cmd_word,
  output logic cmd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // pin level: resistor wins only while the device lets go
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
  initial begin
    cmd_word = 16'h0;
    cmd_valid = 1'b0;
  end
  // ==========================================================
  // two commands back to back, chip address in the low two bits
  task automatic send_two(input logic [15:0] w0, input logic [15:0] w1);
    cmd_word <= w0;
    cmd_valid <= 1'b1;
    @(posedge core_clk);
    cmd_word <= w1;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_word <= ~w1;
    @(posedge core_clk);
  endtask
endmodule // rsc_host_model
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the strap loader
// Assumes: minimum reset length shortened to 20 cycles
// Notes: rows cover all four addresses, both roles, both pin functions
`default_nettype none
module testbench
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] straps; logic [1:0] addr; logic slave; logic mod;} rsc_row_s;
  rsc_row_s rows [4] = '{'{4'h0, 2'h0, 1'h0, 1'h1}, '{4'h5, 2'h1, 1'h1, 1'h1},
                         '{4'ha, 2'h2, 1'h0, 1'h0}, '{4'hf, 2'h3, 1'h1, 1'h0}};
  logic core_clk = 1'b0, rst = 1'b1, rst_n_pin = 1'b1, slip_event = 1'b0, ext_clk = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0, pull = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, bco, bcoe, lco, lcoe, mcoe, bcs, lcs;
  logic [1:0] bresp, rresp, r, chip_addr;
  logic [4:0] pat = 5'h0;
  logic [15:0] cmd_word, cmd_data;
  logic cmd_valid, cmd_write, sys_reset, slave_role, mod_enable, gpio_enable;
  wire logic [3:0] pin_in, pin_out, pin_oe;
  int n_fail = 0, n_tests = 0, n_wr = 0, low_cnt = 0, cyc = 0, base;

  rsc_loader #(.RST_MIN(20)) dut_u (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .reset_n_pin(rst_n_pin),
    .addr_strap_low_pin_in(pin_in[0]), .addr_strap_low_pin_out(pin_out[0]),
    .addr_strap_low_pin_oe(pin_oe[0]), .addr_strap_high_pin_in(pin_in[1]),
    .addr_strap_high_pin_out(pin_out[1]), .addr_strap_high_pin_oe(pin_oe[1]),
    .role_strap_pin_in(pin_in[2]), .role_strap_pin_out(pin_out[2]), .role_strap_pin_oe(pin_oe[2]),
    .irq_n_pin_in(pin_in[3]), .irq_n_pin_out(pin_out[3]), .irq_n_pin_oe(pin_oe[3]),
    .rx_bit_clock_in(bcoe ? bco : ext_clk), .rx_bit_clock_out(bco), .rx_bit_clock_oe(bcoe),
    .rx_lr_clock_in(lcoe ? lco : ext_clk), .rx_lr_clock_out(lco), .rx_lr_clock_oe(lcoe),
    .rx_master_clock_oe(mcoe), .low_func_out(pat[0]), .high_func_out(pat[1]),
    .role_func_out(pat[2]), .gen_bit_clock(pat[3]), .gen_lr_clock(pat[4]),
    .bit_clock_sync(bcs), .lr_clock_sync(lcs), .slip_event(slip_event), .cmd_word(cmd_word),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_data(cmd_data), .sys_reset(sys_reset),
    .chip_addr(chip_addr), .slave_role(slave_role), .mod_enable(mod_enable),
    .gpio_enable(gpio_enable));

  rsc_host_model host_u (.core_clk(core_clk), .pull(pull), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in(pin_in), .cmd_word(cmd_word), .cmd_valid(cmd_valid));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // ==========================================================
  // monitors and watchdog
  always @(posedge core_clk) begin
    pat <= pat + 5'h1;
    ext_clk <= ~ext_clk;
    cyc <= cyc + 1;
    if (cmd_write === 1'b1) n_wr <= n_wr + 1;
    if (pin_out[3] === 1'b0) low_cnt <= low_cnt + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic tally_and_finish();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      pull <= rows[i].straps;
      rst_n_pin <= 1'b0;
      repeat (30) @(posedge core_clk);
      chk(sys_reset, 1'b1);
      chk(pin_oe, 4'h0);
      chk({mod_enable, gpio_enable}, 2'h0);
      rst_n_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      pull <= ~rows[i].straps;
      repeat (3) @(posedge core_clk);
      chk(sys_reset, 1'b0);
      chk(pin_oe, 4'hf);
      chk(chip_addr, rows[i].addr);
      chk(slave_role, rows[i].slave);
      chk({mod_enable, gpio_enable}, {rows[i].mod, ~rows[i].mod});
      chk({bcoe, lcoe, mcoe}, {~rows[i].slave, ~rows[i].slave, 1'b1});
      d = 32'(pat - 5'h2);
      chk({bcs, lcs}, rows[i].slave ? {2{ext_clk}} : {d[3], d[4]});
      chk({pin_out[2:0], bco, lco}, {pat[2:0], pat[3], pat[4]});
      rd(STRAP_OFS, d, r);
      chk(r, RESP_OKAY);
      chk(d, {28'h0, rows[i].straps});
    end
    rd(STAT_OFS, d, r);
    chk(d, 32'h0);
    host_u.send_two(16'h48d3, 16'h0109);
    repeat (2) @(posedge core_clk);
    chk(n_wr, 1);
    chk(cmd_data, 16'h48d3);
    rd(CMD_OFS, d, r);
    chk(d, 32'h48d3);
    slip_event <= 1'b1;
    @(posedge core_clk);
    slip_event <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(STAT_OFS, d, r);
    chk(d, 32'h3);
    chk(irq, 1'b0);
    wr(MASK_OFS, 32'h1, r);
    chk(r, RESP_OKAY);
    chk({irq, pin_out[3]}, 2'h2);
    wr(STAT_OFS, 32'h1, r);
    chk(irq, 1'b0);
    rd(STAT_OFS, d, r);
    chk(d, 32'h2);
    rd(8'h20, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h24, 32'h5, r);
    chk(r, RESP_SLVERR);
    wr(STAT_OFS, 32'h7, r);
    wr(MASK_OFS, 32'h2, r);
    wr(CTRL_OFS, 32'h1, r);
    base = low_cnt;
    host_u.send_two(16'h0001, 16'h0002);
    repeat (600) @(posedge core_clk);
    chk(low_cnt - base >= IRQ_MIN_CYC && low_cnt - base <= IRQ_MAX_CYC, 1'b1);
    chk({irq, pin_out[3]}, 2'h3);
    chk(n_wr, 1);
    wr(STAT_OFS, 32'h7, r);
    rst_n_pin <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(STAT_OFS, d, r);
    chk(d[2], 1'b1);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
